// >>> verilog/pio_mux_params.svh
// Named constants for the programmable pin multiplexer and its timer paths.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PIO_MUX_PARAMS_SVH
`define PIO_MUX_PARAMS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define PIN_COUNT       19
`define TP_CNT_W        32
`define STAMP_W         32

// ****************************************************************
// Pin positions
// ****************************************************************
`define PIN_TP_A        2
`define PIN_TP_B        3
`define PIN_U2_ALT2_TX  2
`define PIN_U2_ALT2_RX  3
`define PIN_U1_TX       6
`define PIN_U1_RX       7
`define PIN_I2C_SCL     8
`define PIN_I2C_SDA     9
`define PIN_IF_STRAP    10
`define PIN_U2_ALT1_RX  10
`define PIN_TP_DEF      11
`define PIN_TM_A        11
`define PIN_BOOT_STRAP  12
`define PIN_U2_ALT1_TX  12
`define PIN_TM_B        13
`define PIN_TM_C        14
`define PIN_ANT_STAT    15
`define PIN_U1_ALT_RX   15
`define PIN_ANT_PWR     16
`define PIN_U1_ALT_TX   16
`define PIN_U2_RX       17
`define PIN_U2_TX       18

// ****************************************************************
// Reset values
// ****************************************************************
`define STRAP_RST       1'b1
`define SERIAL_IDLE     1'b1
`define PULLUP_RST      2'b11
`define TP_CNT_ZERO     32'h0000_0000
`define TP_CNT_ONE      32'h0000_0001

`endif

// >>> verilog/pio_mux_pkg.sv
// Types shared by the pin multiplexer and its timer paths.
// Assumes the constants header is on the include path.
`default_nettype none
`include "pio_mux_params.svh"

package pio_mux_pkg;

	// ****************************************************************
	// Routing choices
	// ****************************************************************
	typedef enum logic [1:0] {AUX_PINS_17_18, AUX_PINS_10_12, AUX_PINS_2_3} aux_place_t;
	typedef enum logic [1:0] {TP_PIN_11, TP_PIN_2, TP_PIN_3, TP_OFF} tp_route_t;
	typedef enum logic [1:0] {TM_OFF, TM_PIN_11, TM_PIN_13, TM_PIN_14} tm_route_t;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic       spi_mode;
		logic       i2c_en;
		aux_place_t aux_place;
		tp_route_t  tp_route;
		tm_route_t  tm_route;
	} mux_cfg_t;

	typedef struct packed {
		logic                 enable;
		logic [`TP_CNT_W-1:0] period;
		logic [`TP_CNT_W-1:0] width;
	} tp_cfg_t;

	typedef struct packed {
		logic                valid;
		logic [`STAMP_W-1:0] stamp;
	} event_stamp_t;

endpackage

`default_nettype wire

// >>> verilog/time_pulse_gen.sv
// Time pulse generator aligned to the time grid.
// Assumes grid_tick is a one-cycle pulse at each grid boundary of the time base.
`default_nettype none
`include "pio_mux_params.svh"

module time_pulse_gen
	import pio_mux_pkg::*;
(
	input  wire logic    core_clk,
	input  wire logic    srst,
	input  wire logic    ce,
	input  wire logic    grid_tick,
	input  wire tp_cfg_t cfg,
	output logic         pulse
);

	logic [`TP_CNT_W-1:0] cnt;
	logic [`TP_CNT_W-1:0] next_cnt;
	logic                 next_pulse;

	// A grid tick restarts the period so the train never drifts from the grid.
	always_comb begin
		next_cnt   = cnt;
		next_pulse = 1'b0;
		if (cfg.enable) begin
			if (grid_tick || cnt >= cfg.period - `TP_CNT_ONE) begin
				next_cnt = `TP_CNT_ZERO;
			end else begin
				next_cnt = cnt + `TP_CNT_ONE;
			end
			next_pulse = (next_cnt < cfg.width);
		end else begin
			next_cnt = `TP_CNT_ZERO;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cnt   <= `TP_CNT_ZERO;
			pulse <= 1'b0;
		end else if (ce) begin
			cnt   <= next_cnt;
			pulse <= next_pulse;
		end
	end

endmodule

`default_nettype wire

// >>> verilog/time_mark_capture.sv
// Time mark capture: synchronises the routed mark and stamps its edges.
// Assumes sat_time is the receiver's time base, valid in every cycle.
`default_nettype none
`include "pio_mux_params.svh"

module time_mark_capture
	import pio_mux_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                srst,
	input  wire logic                ce,
	input  wire logic                mark_raw,
	input  wire logic [`STAMP_W-1:0] sat_time,
	output event_stamp_t             ext_event_line_0,
	output event_stamp_t             ext_event_line_1
);

	logic         sync_a;
	logic         sync_b;
	logic         prev;
	event_stamp_t next_line_0;
	event_stamp_t next_line_1;

	// Rising edges go to line 0, falling edges to line 1.
	always_comb begin
		next_line_0.valid = sync_b & ~prev;
		next_line_0.stamp = next_line_0.valid ? sat_time : ext_event_line_0.stamp;
		next_line_1.valid = ~sync_b & prev;
		next_line_1.stamp = next_line_1.valid ? sat_time : ext_event_line_1.stamp;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			sync_a           <= 1'b0;
			sync_b           <= 1'b0;
			prev             <= 1'b0;
			ext_event_line_0 <= '0;
			ext_event_line_1 <= '0;
		end else if (ce) begin
			sync_a           <= mark_raw;
			sync_b           <= sync_a;
			prev             <= sync_b;
			ext_event_line_0 <= next_line_0;
			ext_event_line_1 <= next_line_1;
		end
	end

endmodule

`default_nettype wire

// >>> verilog/pio_mux_time_pulse_routing.sv
// Programmable pin multiplexer with time mark and time pulse routing.
// Assumes pin inputs are synchronous to core_clk and pads resolve drive from pin_oe.
//
// Functional notes
// - Every pin is GPIO or one of its listed alternate functions.
// - Interface strap high at startup puts primary serial transmit on pin 6.
// - Interface strap high at startup puts primary serial receive on pin 7.
// - Strap pins 10 and 12 have pull-ups forced on by default.
// - Time mark comes from at most one of pins 11, 13, 14; none when routing is off.
// - Time mark edges pass through two event lines and get time stamps.
// - Time pulse goes to pin 2, 3 or 11; pin 11 by default.
// - Time pulse drives at most one pin; others keep their GPIO or serial use.
// - Time pulse train follows the time grid with a configurable interval.
// - Antenna power control on pin 16 follows antenna status on pin 15.
// - With pins 6 and 7 taken for SPI, primary serial moves to 15/16.
// - Aux serial uses pins 17/18 by default, else 10/12 or 2/3.
`default_nettype none
`include "pio_mux_params.svh"

module pio_mux_time_pulse_routing
	import pio_mux_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  srst,
	input  wire logic                  ce,
	input  wire logic [`PIN_COUNT-1:0] pin_in,
	output logic      [`PIN_COUNT-1:0] pin_out,
	output logic      [`PIN_COUNT-1:0] pin_oe,
	output logic      [1:0]            strap_pullup_en,
	input  wire mux_cfg_t              mux_cfg,
	input  wire tp_cfg_t               tp_cfg,
	input  wire logic [`PIN_COUNT-1:0] gpio_out,
	input  wire logic [`PIN_COUNT-1:0] gpio_oe,
	output logic      [`PIN_COUNT-1:0] gpio_in,
	input  wire logic                  primary_serial_port_tx,
	output logic                       primary_serial_port_rx,
	input  wire logic                  aux_serial_port_tx,
	output logic                       aux_serial_port_rx,
	input  wire logic                  i2c_scl_drive_low,
	input  wire logic                  i2c_sda_drive_low,
	output logic                       i2c_scl_in,
	output logic                       i2c_sda_in,
	output logic                       interface_select_strap,
	output logic                       boot_strap,
	output logic                       antenna_status_in,
	input  wire logic                  grid_tick,
	input  wire logic [`STAMP_W-1:0]   sat_time,
	output event_stamp_t               ext_event_line_0,
	output event_stamp_t               ext_event_line_1
);

	// ****************************************************************
	// Strap capture
	// ****************************************************************
	logic in_reset;
	logic next_in_reset;
	logic next_if_strap;
	logic next_boot_strap;

	// The straps are taken from the pins at the first enabled edge after release.
	always_comb begin
		next_in_reset   = 1'b0;
		next_if_strap   = interface_select_strap;
		next_boot_strap = boot_strap;
		if (in_reset) begin
			next_if_strap   = pin_in[`PIN_IF_STRAP];
			next_boot_strap = pin_in[`PIN_BOOT_STRAP];
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			in_reset               <= 1'b1;
			interface_select_strap <= `STRAP_RST;
			boot_strap             <= `STRAP_RST;
			strap_pullup_en        <= `PULLUP_RST;
		end else if (ce) begin
			in_reset               <= next_in_reset;
			interface_select_strap <= next_if_strap;
			boot_strap             <= next_boot_strap;
		end
	end

	// ****************************************************************
	// Time pulse and time mark paths
	// ****************************************************************
	logic tp_pulse;
	logic mark_raw;

	time_pulse_gen u_time_pulse_gen (
		.core_clk  (core_clk),
		.srst      (srst),
		.ce        (ce),
		.grid_tick (grid_tick),
		.cfg       (tp_cfg),
		.pulse     (tp_pulse)
	);

	// At most one pin feeds the mark path; the others are ignored.
	always_comb begin
		case (mux_cfg.tm_route)
			TM_PIN_11: mark_raw = pin_in[`PIN_TM_A];
			TM_PIN_13: mark_raw = pin_in[`PIN_TM_B];
			TM_PIN_14: mark_raw = pin_in[`PIN_TM_C];
			default:   mark_raw = 1'b0;
		endcase
	end

	time_mark_capture u_time_mark_capture (
		.core_clk         (core_clk),
		.srst             (srst),
		.ce               (ce),
		.mark_raw         (mark_raw),
		.sat_time         (sat_time),
		.ext_event_line_0 (ext_event_line_0),
		.ext_event_line_1 (ext_event_line_1)
	);

	// ****************************************************************
	// Pin function selection
	// ****************************************************************
	logic                  u1_on_main;
	logic                  u1_on_alt;
	logic [`PIN_COUNT-1:0] next_pin_out;
	logic [`PIN_COUNT-1:0] next_pin_oe;
	logic                  next_u1_rx;
	logic                  next_u2_rx;
	logic                  next_ant_status;

	assign u1_on_main = interface_select_strap & ~mux_cfg.spi_mode;
	assign u1_on_alt  = interface_select_strap & mux_cfg.spi_mode;

	// Later assignments override earlier ones, so the order below is the
	// priority: GPIO, then serial and I2C, then antenna, then the timer paths.
	always_comb begin
		next_pin_out    = gpio_out;
		next_pin_oe     = gpio_oe;
		next_u1_rx      = `SERIAL_IDLE;
		next_u2_rx      = `SERIAL_IDLE;
		next_ant_status = pin_in[`PIN_ANT_STAT];

		// Strap pins stay undriven until their levels have been taken.
		if (in_reset) begin
			next_pin_oe[`PIN_IF_STRAP]   = 1'b0;
			next_pin_oe[`PIN_BOOT_STRAP] = 1'b0;
		end

		if (u1_on_main) begin
			next_pin_out[`PIN_U1_TX] = primary_serial_port_tx;
			next_pin_oe[`PIN_U1_TX]  = 1'b1;
			next_pin_oe[`PIN_U1_RX]  = 1'b0;
			next_u1_rx               = pin_in[`PIN_U1_RX];
		end else if (u1_on_alt) begin
			next_pin_out[`PIN_U1_ALT_TX] = primary_serial_port_tx;
			next_pin_oe[`PIN_U1_ALT_TX]  = 1'b1;
			next_pin_oe[`PIN_U1_ALT_RX]  = 1'b0;
			next_u1_rx                   = pin_in[`PIN_U1_ALT_RX];
		end

		case (mux_cfg.aux_place)
			AUX_PINS_10_12: begin
				next_pin_out[`PIN_U2_ALT1_TX] = aux_serial_port_tx;
				next_pin_oe[`PIN_U2_ALT1_TX]  = ~in_reset;
				next_pin_oe[`PIN_U2_ALT1_RX]  = 1'b0;
				next_u2_rx                    = pin_in[`PIN_U2_ALT1_RX];
			end
			AUX_PINS_2_3: begin
				next_pin_out[`PIN_U2_ALT2_TX] = aux_serial_port_tx;
				next_pin_oe[`PIN_U2_ALT2_TX]  = 1'b1;
				next_pin_oe[`PIN_U2_ALT2_RX]  = 1'b0;
				next_u2_rx                    = pin_in[`PIN_U2_ALT2_RX];
			end
			default: begin
				next_pin_out[`PIN_U2_TX] = aux_serial_port_tx;
				next_pin_oe[`PIN_U2_TX]  = 1'b1;
				next_pin_oe[`PIN_U2_RX]  = 1'b0;
				next_u2_rx               = pin_in[`PIN_U2_RX];
			end
		endcase

		// I2C lines are open drain: they only ever pull low.
		if (mux_cfg.i2c_en) begin
			next_pin_out[`PIN_I2C_SCL] = 1'b0;
			next_pin_oe[`PIN_I2C_SCL]  = i2c_scl_drive_low;
			next_pin_out[`PIN_I2C_SDA] = 1'b0;
			next_pin_oe[`PIN_I2C_SDA]  = i2c_sda_drive_low;
		end

		// The antenna pins are lost while the primary port sits on them.
		if (!u1_on_alt) begin
			next_pin_oe[`PIN_ANT_STAT] = 1'b0;
			next_pin_out[`PIN_ANT_PWR] = ~antenna_status_in;
			next_pin_oe[`PIN_ANT_PWR]  = 1'b1;
		end

		// A time mark input on pin 11 keeps the pulse off that pin.
		if (mux_cfg.tm_route == TM_PIN_11) begin
			next_pin_oe[`PIN_TM_A] = 1'b0;
		end else if (mux_cfg.tm_route == TM_PIN_13) begin
			next_pin_oe[`PIN_TM_B] = 1'b0;
		end else if (mux_cfg.tm_route == TM_PIN_14) begin
			next_pin_oe[`PIN_TM_C] = 1'b0;
		end

		// The unselected pulse pins fall back to GPIO or their serial use.
		case (mux_cfg.tp_route)
			TP_PIN_2: begin
				next_pin_out[`PIN_TP_A] = tp_pulse;
				next_pin_oe[`PIN_TP_A]  = 1'b1;
			end
			TP_PIN_3: begin
				next_pin_out[`PIN_TP_B] = tp_pulse;
				next_pin_oe[`PIN_TP_B]  = 1'b1;
			end
			TP_PIN_11: begin
				if (mux_cfg.tm_route != TM_PIN_11) begin
					next_pin_out[`PIN_TP_DEF] = tp_pulse;
					next_pin_oe[`PIN_TP_DEF]  = 1'b1;
				end
			end
			default: begin
			end
		endcase
	end

	// ****************************************************************
	// Registered pins and user-side levels
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pin_out                <= '0;
			pin_oe                 <= '0;
			gpio_in                <= '0;
			primary_serial_port_rx <= `SERIAL_IDLE;
			aux_serial_port_rx     <= `SERIAL_IDLE;
			i2c_scl_in             <= 1'b1;
			i2c_sda_in             <= 1'b1;
			antenna_status_in      <= 1'b0;
		end else if (ce) begin
			pin_out                <= next_pin_out;
			pin_oe                 <= next_pin_oe;
			gpio_in                <= pin_in;
			primary_serial_port_rx <= next_u1_rx;
			aux_serial_port_rx     <= next_u2_rx;
			i2c_scl_in             <= pin_in[`PIN_I2C_SCL];
			i2c_sda_in             <= pin_in[`PIN_I2C_SDA];
			antenna_status_in      <= next_ant_status;
		end
	end

endmodule

`default_nettype wire

// >>> tb/pio_mux_asserts.sv
// Checker for the pin multiplexer: routing, straps and timer paths.
// Assumes it is bound onto the top module and that ce stays high.
`default_nettype none
`include "pio_mux_params.svh"

module pio_mux_asserts
	import pio_mux_pkg::*;
(
	input wire logic                  core_clk,
	input wire logic                  srst,
	input wire logic [`PIN_COUNT-1:0] pin_in,
	input wire logic [`PIN_COUNT-1:0] pin_out,
	input wire logic [`PIN_COUNT-1:0] pin_oe,
	input wire logic [1:0]            strap_pullup_en,
	input wire mux_cfg_t              mux_cfg,
	input wire tp_cfg_t               tp_cfg,
	input wire logic [`PIN_COUNT-1:0] gpio_oe,
	input wire logic                  primary_serial_port_tx,
	input wire logic                  primary_serial_port_rx,
	input wire logic                  aux_serial_port_tx,
	input wire logic                  interface_select_strap,
	input wire logic                  antenna_status_in,
	input wire event_stamp_t          ext_event_line_0
);
	// **********
	// Settling
	// **********
	// Pins follow the config only from the second edge after reset, so wait three.
	logic [1:0] age;
	logic       rdy;
	always_ff @(posedge core_clk) begin
		if (srst) age <= 2'h0;
		else if (age != 2'h3) age <= age + 2'h1;
	end
	assign rdy = age == 2'h3;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence s_mark_rise;
		rdy && $rose(pin_in[13]) && mux_cfg.tm_route == TM_PIN_13
			##1 (mux_cfg.tm_route == TM_PIN_13) [*3];
	endsequence
	sequence s_tp_idle;
		(rdy && mux_cfg.tp_route == TP_PIN_2 && !tp_cfg.enable) [*3];
	endsequence

	a_pullup_on: assert property (strap_pullup_en == 2'h3)
		else $error("strap pull-ups not enabled");
	a_tx_pin6: assert property (rdy && interface_select_strap && !mux_cfg.spi_mode
		|=> pin_oe[6] && pin_out[6] == $past(primary_serial_port_tx))
		else $error("serial transmit missing on pin 6");
	a_rx_pin7: assert property (rdy && interface_select_strap && !mux_cfg.spi_mode
		|=> primary_serial_port_rx == $past(pin_in[7]))
		else $error("serial receive not from pin 7");
	a_tx_remap: assert property (rdy && interface_select_strap && mux_cfg.spi_mode
		|=> pin_oe[16] && pin_out[16] == $past(primary_serial_port_tx))
		else $error("serial transmit not moved to pin 16");
	a_aux_home: assert property (rdy && mux_cfg.aux_place == AUX_PINS_17_18
		|=> pin_oe[18] && pin_out[18] == $past(aux_serial_port_tx))
		else $error("aux transmit missing on pin 18");
	a_tp_one_pin: assert property (rdy && mux_cfg.tp_route == TP_PIN_2 && !gpio_oe[11]
		|=> pin_oe[2] && !pin_oe[11])
		else $error("time pulse not on pin 2 alone");
	a_tp_off: assert property (s_tp_idle |-> !pin_out[2])
		else $error("time pulse while disabled");
	a_antenna_follow: assert property (rdy && !(interface_select_strap && mux_cfg.spi_mode)
		|=> pin_oe[16] && pin_out[16] == !$past(antenna_status_in))
		else $error("antenna control does not follow status");
	a_mark_rise: assert property (s_mark_rise |-> ##[0:3] ext_event_line_0.valid)
		else $error("time mark rise not reported");
	a_strap_hold: assert property (rdy |-> $stable(interface_select_strap))
		else $error("strap level changed after latch");
endmodule

`default_nettype wire

// >>> tb/pin_board_model.sv
// Board model: resolves each pad from device drive, board drive and pull-ups.
// Assumes the bench gives a drive value and enable for every pin.
`default_nettype none

module pin_board_model (
	input  wire logic        core_clk,
	input  wire logic [18:0] pin_out,
	input  wire logic [18:0] pin_oe,
	input  wire logic [1:0]  strap_pullup_en,
	input  wire logic [18:0] board_val,
	input  wire logic [18:0] board_oe,
	output logic      [18:0] pin_in
);
	// **********
	// Pads
	// **********
	// A floating pad flips every cycle so that no settled level hides a fault.
	logic flip;
	initial flip = 1'b0;
	always @(posedge core_clk) flip <= !flip;
	always_comb begin
		pin_in = {19{flip}};
		for (int i = 0; i < 19; i++) begin
			if (pin_oe[i]) pin_in[i] = pin_out[i];
			else if (board_oe[i]) pin_in[i] = board_val[i];
		end
		if (!pin_oe[10] && !board_oe[10] && strap_pullup_en[0]) pin_in[10] = 1'b1;
		if (!pin_oe[12] && !board_oe[12] && strap_pullup_en[1]) pin_in[12] = 1'b1;
	end
endmodule

`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the pin multiplexer and its timer paths.
// Assumes the board model on the pads; ce is held high throughout.
`default_nettype none
`include "pio_mux_params.svh"

module testbench
	import pio_mux_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TXP [3] = '{18, 12, 2};
	localparam int RXP [3] = '{17, 10, 3};
	localparam int TPP [3] = '{11, 2, 3};
	localparam int TMP [3] = '{11, 13, 14};
	logic         core_clk, srst, grid_tick, ptx, atx, scl_low, sda_low;
	logic         prx, arx, scl_in, sda_in, ifs, bts, ants;
	logic [18:0]  gpio_out, gpio_oe, bval, boe, pin_in, pin_out, pin_oe, gpio_in;
	logic [31:0]  st;
	logic [1:0]   pu;
	mux_cfg_t     mc;
	tp_cfg_t      tc;
	event_stamp_t e0, e1;
	int           n_errors = 0;
	int           cmp_count = 0;

	pio_mux_time_pulse_routing pio_mux_time_pulse_routing_i (
		.core_clk(core_clk), .srst(srst), .ce(1'b1), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .strap_pullup_en(pu), .mux_cfg(mc), .tp_cfg(tc), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe), .gpio_in(gpio_in), .primary_serial_port_tx(ptx),
		.primary_serial_port_rx(prx), .aux_serial_port_tx(atx), .aux_serial_port_rx(arx),
		.i2c_scl_drive_low(scl_low), .i2c_sda_drive_low(sda_low), .i2c_scl_in(scl_in),
		.i2c_sda_in(sda_in), .interface_select_strap(ifs), .boot_strap(bts),
		.antenna_status_in(ants), .grid_tick(grid_tick), .sat_time(st),
		.ext_event_line_0(e0), .ext_event_line_1(e1));
	pin_board_model pin_board_model_i (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.strap_pullup_en(pu), .board_val(bval), .board_oe(boe), .pin_in(pin_in));

	// **********
	// Helpers
	// **********
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %0h, want %0h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wrap_up;
		$display("mismatches %0d, comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Counts high samples on one pin; the first eight cycles let the route settle.
	task automatic count_hi(input int p, input logic tick, output int c);
		c = 0;
		for (int i = 0; i < 24; i++) begin
			@(posedge core_clk) grid_tick <= tick && (i % 4 == 0);
			#1;
			if (i >= 8) c += pin_out[p];
		end
		@(posedge core_clk) grid_tick <= 1'b0;
		#1;
	endtask
	task automatic wait_ev(input logic line, input logic [31:0] t0);
		int w;
		event_stamp_t ev;
		w = 0;
		ev = '0;
		while (ev.valid !== 1'b1 && w < 10) begin
			cyc(1);
			ev = line ? e1 : e0;
			w++;
		end
		chk(ev.valid, 1'b1);
		chk((ev.stamp - t0) - 32'h1 < 32'h7, 1'b1);
	endtask

	// **********
	// Scenarios
	// **********
	task automatic t_straps;
		chk({ifs, bts, pu}, 4'hF);
		@(posedge core_clk) begin
			boe[10] <= 1'b1;
			bval[10] <= 1'b0;
		end
		cyc(3);
		chk(ifs, 1'b1);
		@(posedge core_clk) boe[10] <= 1'b0;
	endtask
	task automatic t_uart;
		for (int v = 0; v < 2; v++) begin
			@(posedge core_clk) begin
				ptx <= v[0];
				boe[7] <= 1'b1;
				bval[7] <= !v[0];
			end
			cyc(3);
			chk({pin_oe[6], pin_out[6]}, {1'b1, v[0]});
			chk(prx, !v[0]);
		end
		@(posedge core_clk) begin
			mc.spi_mode <= 1'b1;
			ptx <= 1'b0;
			boe[15] <= 1'b1;
			bval[15] <= 1'b0;
		end
		cyc(3);
		chk({pin_oe[16], pin_out[16], prx, pin_oe[6]}, 4'h8);
		@(posedge core_clk) mc.spi_mode <= 1'b0;
	endtask
	task automatic t_aux;
		for (int k = 0; k < 3; k++) begin
			@(posedge core_clk) begin
				mc.aux_place <= aux_place_t'(k);
				atx <= k[0];
				boe[RXP[k]] <= 1'b1;
				bval[RXP[k]] <= !k[0];
			end
			cyc(3);
			chk({pin_oe[TXP[k]], pin_out[TXP[k]], arx}, {1'b1, k[0], !k[0]});
		end
		@(posedge core_clk) begin
			mc.aux_place <= AUX_PINS_17_18;
			boe <= '0;
		end
	endtask
	task automatic t_pulse;
		int c;
		@(posedge core_clk) tc <= '{1'b1, 32'h0000_0008, 32'h0000_0003};
		for (int k = 0; k < 3; k++) begin
			@(posedge core_clk) mc.tp_route <= tp_route_t'(k);
			count_hi(TPP[k], 1'b0, c);
			chk(c, 6);
			chk({pin_oe[11], pin_oe[2], pin_oe[3]}, 3'h4 >> k);
		end
		count_hi(3, 1'b1, c);
		chk(c, 12);
		@(posedge core_clk) begin
			tc.enable <= 1'b0;
			mc.tp_route <= TP_PIN_2;
		end
		count_hi(2, 1'b0, c);
		chk(c, 0);
		@(posedge core_clk) mc.tp_route <= TP_PIN_11;
	endtask
	task automatic t_mark;
		int c;
		logic [31:0] t0;
		for (int k = 0; k < 3; k++) begin
			@(posedge core_clk) begin
				boe[TMP[k]] <= 1'b1;
				bval[TMP[k]] <= 1'b0;
			end
			@(posedge core_clk) mc.tm_route <= tm_route_t'(k + 1);
			c = 0;
			repeat (8) begin
				cyc(1);
				c += e0.valid | e1.valid;
			end
			chk({c[3:0], pin_oe[11]}, {4'h0, k != 0});
			@(posedge core_clk) begin
				bval[TMP[k]] <= 1'b1;
				t0 = st;
			end
			wait_ev(1'b0, t0);
			@(posedge core_clk) begin
				bval[TMP[k]] <= 1'b0;
				t0 = st;
			end
			wait_ev(1'b1, t0);
		end
		@(posedge core_clk) begin
			mc.tm_route <= TM_OFF;
			boe <= '0;
		end
	endtask
	task automatic t_antenna;
		for (int v = 0; v < 2; v++) begin
			@(posedge core_clk) begin
				boe[15] <= 1'b1;
				bval[15] <= v[0];
			end
			cyc(3);
			chk({ants, pin_oe[16], pin_out[16]}, {v[0], 1'b1, !v[0]});
		end
	endtask
	task automatic t_gpio;
		@(posedge core_clk) begin
			gpio_oe[0] <= 1'b1;
			gpio_out[0] <= 1'b1;
			boe[9:1] <= 9'h101;
			bval[9:1] <= 9'h101;
			mc.i2c_en <= 1'b1;
			scl_low <= 1'b1;
		end
		cyc(3);
		chk({pin_oe[0], pin_out[0], gpio_in[1]}, 3'h7);
		chk({pin_oe[8], pin_out[8], pin_oe[9], scl_in, sda_in}, 5'h11);
		@(posedge core_clk) begin
			scl_low <= 1'b0;
			sda_low <= 1'b1;
		end
		cyc(3);
		chk({pin_oe[8], pin_oe[9], pin_out[9], sda_in}, 4'h4);
	endtask
	task automatic t_reset2;
		@(posedge core_clk) begin
			srst <= 1'b1;
			boe[10] <= 1'b1;
			bval[10] <= 1'b0;
		end
		repeat (4) @(posedge core_clk);
		srst <= 1'b0;
		cyc(3);
		chk({ifs, bts, pin_oe[6], prx}, 4'h5);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = !core_clk;
	end
	always @(posedge core_clk) st <= st + 32'h1;
	initial begin
		repeat (4000) @(posedge core_clk);
		n_errors++;
		wrap_up();
	end
	initial begin
		{srst, grid_tick, ptx, atx, scl_low, sda_low} = 6'h2C;
		{gpio_out, gpio_oe, bval, boe} = '0;
		st = '0;
		mc = '{1'b0, 1'b0, AUX_PINS_17_18, TP_PIN_11, TM_OFF};
		tc = '0;
		repeat (4) @(posedge core_clk);
		srst <= 1'b0;
		cyc(3);
		t_straps();
		t_uart();
		t_aux();
		t_pulse();
		t_mark();
		t_antenna();
		t_gpio();
		t_reset2();
		wrap_up();
	end
endmodule

bind pio_mux_time_pulse_routing pio_mux_asserts pio_mux_asserts_i (
	.core_clk(core_clk), .srst(srst), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
	.strap_pullup_en(strap_pullup_en), .mux_cfg(mux_cfg), .tp_cfg(tp_cfg), .gpio_oe(gpio_oe),
	.primary_serial_port_tx(primary_serial_port_tx),
	.primary_serial_port_rx(primary_serial_port_rx), .aux_serial_port_tx(aux_serial_port_tx),
	.interface_select_strap(interface_select_strap), .antenna_status_in(antenna_status_in),
	.ext_event_line_0(ext_event_line_0));

`default_nettype wire
